// File: src/branch_unit_pkg.sv
// package for the branch and machine cycle unit
// assumes one clock, synchronous active-high reset
`default_nettype none
package branch_unit_pkg;
  localparam int STATE_COUNT     = 6;   // states per machine cycle
  localparam int PHASE_COUNT     = 2;   // oscillator periods per state
  localparam int OSC_PER_CYCLE   = STATE_COUNT * PHASE_COUNT;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam int PAGE_BITS       = 11;  // page jump/call field width

  // control-flow operation requested by the core decoder
  typedef enum logic [3:0] {
    op_none, op_long_jump, op_page_jump, op_short_jump, op_indexed_jump,
    op_long_call, op_page_call, op_return, op_interrupt_return,
    op_branch_if_acc_zero, op_branch_if_acc_nonzero,
    op_decrement_branch_nonzero, op_compare_branch_unequal,
    op_external_data_move
  } flow_op_type;

  // one decoded instruction as handed to the unit
  typedef struct packed {
    flow_op_type op;
    logic [2:0]  page_hi;   // upper 3 target bits from opcode byte
    logic [7:0]  byte1;     // first operand byte (offset or address)
    logic [7:0]  byte2;     // second operand byte
    logic [7:0]  cmp_a;     // first compare or decrement operand
    logic [7:0]  cmp_b;     // second compare operand
  } flow_req_type;

  // external bus strobes
  typedef struct packed {
    logic        addr_latch;    // address latch strobe, high active
    logic        prog_store_n;  // program store strobe, low active
    logic [7:0]  port_zero;     // low address byte
  } bus_pins_type;
endpackage
`default_nettype wire

// File: src/branch_and_machine_cycle_unit.sv
// control-flow executor and machine cycle sequencer
// assumes a decoder presents one request per machine cycle start and
// that oscillator ticks are one-cycle enables on clk_sys
//
// Contract
// - long jump: three bytes, full 16-bit target anywhere in 64K.
// - page jump: two bytes, 3 bits in opcode, low 8 bits next.
// - page jump/call replace low 11 PC bits, keep upper 5.
// - indexed jump loads data pointer plus accumulator into PC.
// - long call takes a full 16-bit subroutine address.
// - page call takes 11-bit address within the same 2K block.
// - return resumes at instruction after the call.
// - interrupt return also flags interrupt done; else plain return.
// - conditional branches reach -128..+127 from next instruction.
// - zero branches test the accumulator directly.
// - decrement operand, branch while result is nonzero.
// - compare branches when unequal; carry set if first is less.
// - machine cycle is six states of two oscillator periods.
// - each state has a first and second phase half.
// - two fetches per cycle; unneeded byte discarded, PC held.
// - opcode latched in first state, second fetch in fourth.
// - external data move: two cycles, no fetch in the second.
// - fetch sequence identical for internal or external memory.
// - external execution strobes program store twice per cycle.
// - data access omits two program strobes, double-length cycle.
// - internal: no program strobe; latch strobe skips one in move.
// - external: low address byte presented on port zero with latch strobe.
// - signed offset added to PC only when branch is taken.
// - stack pointer incremented before each stored byte; resets 07.
`default_nettype none
module branch_and_machine_cycle_unit (
  input  wire logic                        clk_sys,
  input  wire logic                        srst,
  input  wire logic                        osc_tick,
  input  wire logic                        external_program,
  input  wire branch_unit_pkg::flow_req_type req,
  input  wire logic                        req_valid,
  input  wire logic [7:0]                  acc,
  input  wire logic [15:0]                 data_pointer,
  input  wire logic [15:0]                 return_addr,
  input  wire logic                        int_in_progress,
  output logic [15:0]                      pc,
  output logic [7:0]                       sp,
  output logic                             carry,
  output logic [7:0]                       dec_result,
  output logic                             dec_write,
  output logic [15:0]                      push_data,
  output logic                             push_write,
  output logic                             int_done,
  output logic [2:0]                       state_num,
  output logic                             phase_two,
  output logic                             cycle_end,
  output branch_unit_pkg::bus_pins_type    bus
);
  import branch_unit_pkg::*;

  logic [2:0]  st;          // 0..5 means first..sixth state
  logic        ph;          // phase half within a state
  logic        move_second; // second cycle of an external data move
  logic        move_first;
  logic        take;
  logic [15:0] next_pc;
  logic [15:0] pc_after;
  logic [7:0]  dec_val;
  logic        at_end;

  assign at_end = osc_tick && ph && (st == 3'(STATE_COUNT - 1));

  // state and phase counters
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= 3'h0;
      ph <= 1'b0;
    end else if (osc_tick) begin
      ph <= ~ph;
      if (ph) begin
        st <= (st == 3'(STATE_COUNT - 1)) ? 3'h0 : st + 3'h1;
      end
    end
  end

  // external data move spans two cycles
  assign move_first = req_valid && req.op == op_external_data_move;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      move_second <= 1'b0;
    end else if (at_end) begin
      move_second <= move_first && !move_second;
    end
  end

  // branch decision and target
  assign dec_val = req.cmp_a - 8'h01;
  always_comb begin
    pc_after = pc;
    take     = 1'b0;
    next_pc  = pc;
    unique case (req.op)
      op_long_jump, op_long_call: begin
        pc_after = pc + 16'h0003;
        next_pc  = {req.byte1, req.byte2};
      end
      op_page_jump, op_page_call: begin
        pc_after = pc + 16'h0002;
        next_pc  = {pc_after[15:PAGE_BITS], req.page_hi, req.byte1};
      end
      op_short_jump: begin
        pc_after = pc + 16'h0002;
        next_pc  = pc_after + {{8{req.byte1[7]}}, req.byte1};
      end
      op_indexed_jump: next_pc = data_pointer + {8'h00, acc};
      op_return, op_interrupt_return: next_pc = return_addr;
      op_branch_if_acc_zero, op_branch_if_acc_nonzero: begin
        pc_after = pc + 16'h0002;
        take = (req.op == op_branch_if_acc_zero) ? (acc == 8'h00)
                                                 : (acc != 8'h00);
        next_pc = take ? pc_after + {{8{req.byte1[7]}}, req.byte1}
                       : pc_after;
      end
      op_decrement_branch_nonzero: begin
        pc_after = pc + 16'h0003;
        take = (dec_val != 8'h00);
        next_pc = take ? pc_after + {{8{req.byte1[7]}}, req.byte1}
                       : pc_after;
      end
      op_compare_branch_unequal: begin
        pc_after = pc + 16'h0003;
        take = (req.cmp_a != req.cmp_b);
        next_pc = take ? pc_after + {{8{req.byte1[7]}}, req.byte1}
                       : pc_after;
      end
      op_external_data_move: next_pc = pc + 16'h0001;
      default: next_pc = pc + 16'h0001;
    endcase
  end

  // program counter; held while a move's second cycle runs
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pc <= PC_RESET;
    end else if (at_end && req_valid && !move_second) begin
      pc <= next_pc;
    end
  end

  // carry only changed by compare
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      carry <= 1'b0;
    end else if (at_end && req_valid && req.op == op_compare_branch_unequal)
    begin
      carry <= (req.cmp_a < req.cmp_b);
    end
  end

  // decrement write-back pulse
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dec_result <= 8'h00;
      dec_write  <= 1'b0;
    end else begin
      dec_write <= at_end && req_valid
                   && req.op == op_decrement_branch_nonzero;
      if (at_end) begin
        dec_result <= dec_val;
      end
    end
  end

  // stack push for calls, pre-increment by two bytes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sp         <= SP_RESET;
      push_data  <= 16'h0000;
      push_write <= 1'b0;
    end else begin
      push_write <= 1'b0;
      if (at_end && req_valid) begin
        if (req.op == op_long_call || req.op == op_page_call) begin
          sp         <= sp + 8'h02;
          push_data  <= pc_after;
          push_write <= 1'b1;
        end else if (req.op == op_return || req.op == op_interrupt_return)
        begin
          sp <= sp - 8'h02;
        end
      end
    end
  end

  // interrupt done pulse only when one is in progress
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      int_done <= 1'b0;
    end else begin
      int_done <= at_end && req_valid && int_in_progress
                  && req.op == op_interrupt_return;
    end
  end

  // bus strobes: latch in phase one of first and fourth states
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bus.addr_latch   <= 1'b0;
      bus.prog_store_n <= 1'b1;
      bus.port_zero    <= 8'h00;
      state_num        <= 3'h0;
      phase_two        <= 1'b0;
      cycle_end        <= 1'b0;
    end else begin
      state_num <= st;
      phase_two <= ph;
      cycle_end <= at_end;
      // latch pulses twice; one dropped in the move's second cycle
      bus.addr_latch <= !ph && ((st == 3'h0 && !move_second)
                                || st == 3'h3);
      // program strobe only external, skipped twice in move cycle
      bus.prog_store_n <= !(external_program && !move_second
                            && (st == 3'h1 || st == 3'h4));
      if (external_program && !ph && (st == 3'h0 || st == 3'h3)) begin
        bus.port_zero <= (st == 3'h0) ? pc[7:0] : pc[7:0] + 8'h01;
      end
    end
  end

  // assertions
  property p_seq_wrap;
    @(posedge clk_sys) disable iff (srst)
      (osc_tick && ph && st == 3'h5) |=> (st == 3'h0);
  endproperty
  a_seq_wrap: assert property (p_seq_wrap)
    else $error("state did not wrap after sixth");

  property p_phase_toggle;
    @(posedge clk_sys) disable iff (srst)
      osc_tick |=> (ph != $past(ph));
  endproperty
  a_phase_toggle: assert property (p_phase_toggle)
    else $error("phase did not toggle");

  property p_internal_no_strobe;
    @(posedge clk_sys) disable iff (srst)
      (!external_program)[*2] |-> bus.prog_store_n;
  endproperty
  a_internal_no_strobe: assert property (p_internal_no_strobe)
    else $error("program strobe active while internal");

  property p_move_no_strobe;
    @(posedge clk_sys) disable iff (srst)
      $past(move_second) |-> bus.prog_store_n;
  endproperty
  a_move_no_strobe: assert property (p_move_no_strobe)
    else $error("program strobe during move cycle");

  property p_page_keep_high;
    @(posedge clk_sys) disable iff (srst)
      (at_end && req_valid && !move_second && req.op == op_page_jump)
      |=> pc[15:11] == $past(pc_after[15:11]);
  endproperty
  a_page_keep_high: assert property (p_page_keep_high)
    else $error("page jump altered upper bits");

  property p_compare_carry;
    @(posedge clk_sys) disable iff (srst)
      (at_end && req_valid && req.op == op_compare_branch_unequal)
      |=> carry == ($past(req.cmp_a) < $past(req.cmp_b));
  endproperty
  a_compare_carry: assert property (p_compare_carry)
    else $error("compare carry wrong");

  property p_call_sp;
    @(posedge clk_sys) disable iff (srst)
      (at_end && req_valid && req.op == op_long_call)
      |=> sp == $past(sp) + 8'h02 && push_write;
  endproperty
  a_call_sp: assert property (p_call_sp)
    else $error("call did not bump stack");

  property p_interrupt_return_done;
    @(posedge clk_sys) disable iff (srst)
      int_done |-> $past(int_in_progress);
  endproperty
  a_interrupt_return_done: assert property (p_interrupt_return_done)
    else $error("done without interrupt in progress");

  property p_dec_not_taken;
    @(posedge clk_sys) disable iff (srst)
      (at_end && req_valid && !move_second
       && req.op == op_decrement_branch_nonzero && dec_val == 8'h00)
      |=> pc == $past(pc) + 16'h0003;
  endproperty
  a_dec_not_taken: assert property (p_dec_not_taken)
    else $error("decrement branch taken at zero");

  property p_latch_states;
    @(posedge clk_sys) disable iff (srst)
      bus.addr_latch
      |-> !phase_two && (state_num == 3'h0 || state_num == 3'h3);
  endproperty
  a_latch_states: assert property (p_latch_states)
    else $error("address latch strobe outside its states");

  property p_strobe_states;
    @(posedge clk_sys) disable iff (srst)
      !bus.prog_store_n
      |-> (state_num == 3'h1 || state_num == 3'h4);
  endproperty
  a_strobe_states: assert property (p_strobe_states)
    else $error("program strobe outside its states");

  property p_move_refused;
    @(posedge clk_sys) disable iff (srst)
      (at_end && req_valid && move_second)
      |=> pc == $past(pc);
  endproperty
  a_move_refused: assert property (p_move_refused)
    else $error("request taken in second move cycle");

  property p_interrupt_return_plain;
    @(posedge clk_sys) disable iff (srst)
      (at_end && req_valid && !int_in_progress
       && req.op == op_interrupt_return)
      |=> !int_done && sp == $past(sp) - 8'h02;
  endproperty
  a_interrupt_return_plain: assert property (p_interrupt_return_plain)
    else $error("interrupt return differs from plain return");

  property p_indexed_sum;
    @(posedge clk_sys) disable iff (srst)
      (at_end && req_valid && !move_second && req.op == op_indexed_jump)
      |=> pc == $past(data_pointer) + {8'h00, $past(acc)};
  endproperty
  a_indexed_sum: assert property (p_indexed_sum)
    else $error("indexed jump target wrong");

  property p_zero_not_taken;
    @(posedge clk_sys) disable iff (srst)
      (at_end && req_valid && !move_second
       && req.op == op_branch_if_acc_zero && acc != 8'h00)
      |=> pc == $past(pc) + 16'h0002;
  endproperty
  a_zero_not_taken: assert property (p_zero_not_taken)
    else $error("zero branch taken with nonzero accumulator");

  property p_carry_hold;
    @(posedge clk_sys) disable iff (srst)
      !(at_end && req_valid && req.op == op_compare_branch_unequal)
      |=> $stable(carry);
  endproperty
  a_carry_hold: assert property (p_carry_hold)
    else $error("carry changed outside a compare");

  property p_long_target;
    @(posedge clk_sys) disable iff (srst)
      (at_end && req_valid && !move_second && req.op == op_long_jump)
      |=> pc == {$past(req.byte1), $past(req.byte2)};
  endproperty
  a_long_target: assert property (p_long_target)
    else $error("long jump target wrong");
endmodule
`default_nettype wire

// File: dv/ext_program_memory_model.sv
// external program memory with its address latch, seen from the bus pins
// assumes one clk_sys domain and the unit's state number and phase outputs
`default_nettype none
module ext_program_memory_model (
  input  wire logic                          clk_sys,
  input  wire logic                          srst,
  input  wire branch_unit_pkg::bus_pins_type bus,
  input  wire logic [2:0]                    state_num,
  input  wire logic                          phase_two,
  output logic [7:0]                         latch_byte,
  output logic [3:0]                         al_seen,
  output logic [3:0]                         ps_seen,
  output logic [4:0]                         cyc_len
);
  timeunit 1ns;
  timeprecision 1ns;
  import branch_unit_pkg::*;
  logic [3:0] al_cnt;
  logic [3:0] ps_cnt;
  logic [4:0] clk_cnt;
  logic       al_q;
  logic       ps_q;
  logic       al_rise;
  logic       ps_fall;
  logic       last;
  assign al_rise = bus.addr_latch & ~al_q;
  assign ps_fall = ~bus.prog_store_n & ps_q;
  assign last    = (state_num == 3'h5) & phase_two;
  // the latch follows the low address byte while its strobe is high
  always_ff @(posedge clk_sys) begin
    if (bus.addr_latch) begin
      latch_byte <= bus.port_zero;
    end
  end
  // strobe edges and clocks counted over each machine cycle
  always_ff @(posedge clk_sys) begin
    al_q <= srst ? 1'b0 : bus.addr_latch;
    ps_q <= srst ? 1'b1 : bus.prog_store_n;
    if (last) begin
      al_seen <= al_cnt + {3'h0, al_rise};
      ps_seen <= ps_cnt + {3'h0, ps_fall};
      cyc_len <= clk_cnt + 5'h01;
    end
    if (srst | last) begin
      al_cnt  <= 4'h0;
      ps_cnt  <= 4'h0;
      // reset edge already shows first_state, so start one short
      clk_cnt <= srst ? 5'h1F : 5'h00;
    end else begin
      al_cnt  <= al_cnt + {3'h0, al_rise};
      ps_cnt  <= ps_cnt + {3'h0, ps_fall};
      clk_cnt <= clk_cnt + 5'h01;
    end
  end
endmodule
`default_nettype wire

// File: dv/tb_branch_and_machine_cycle_unit.sv
// self-checking bench for the branch and machine cycle unit
// assumes osc_tick every clk_sys cycle, so a machine cycle is 12 clocks
`default_nettype none
module tb_branch_and_machine_cycle_unit;
  timeunit 1ns;
  timeprecision 1ns;
  import branch_unit_pkg::*;
  typedef struct packed {
    flow_op_type op;
    logic [2:0]  hi;
    logic [15:0] bb;
    logic [7:0]  av;
    logic [15:0] ab;
    logic        ii;
  } row_type;
  logic         clk_sys          = 1'b0;
  logic         srst             = 1'b1;
  logic         osc_tick         = 1'b1;
  logic         external_program = 1'b0;
  flow_req_type req              = '0;
  logic         req_valid        = 1'b0;
  logic [7:0]   acc              = 8'h00;
  logic [15:0]  data_pointer     = 16'hF0F0;
  logic [15:0]  return_addr      = 16'h2468;
  logic         int_in_progress  = 1'b0;
  logic [15:0]  pc, push_data, e_pc;
  logic [7:0]   sp, dec_result, latch_byte, e_sp;
  logic         carry, dec_write, push_write, int_done, phase_two, e_c;
  logic         cycle_end, s_pw, s_dw, s_id, s_ce;
  logic [2:0]   state_num;
  logic [3:0]   al_seen, ps_seen;
  logic [4:0]   cyc_len;
  bus_pins_type bus;
  row_type      rows [18];
  int           n_fail = 0;
  int           cmp_count = 0;
  always #25 clk_sys = ~clk_sys;
  branch_and_machine_cycle_unit dut (.clk_sys, .srst, .osc_tick,
    .external_program, .req, .req_valid, .acc, .data_pointer, .return_addr,
    .int_in_progress, .pc, .sp, .carry, .dec_result, .dec_write, .push_data,
    .push_write, .int_done, .state_num, .phase_two, .cycle_end, .bus);
  ext_program_memory_model mem (.clk_sys, .srst, .bus, .state_num,
    .phase_two, .latch_byte, .al_seen, .ps_seen, .cyc_len);
  // comparisons of words and of single flags
  task automatic chk_word(input string nm, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, g);
    chk_word(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // hold a request until the edge that closes the machine cycle
  task automatic issue(input flow_req_type r);
    req = r;
    req_valid = 1'b1;
    for (int k = 0; k < 14 && !(state_num === 3'h5 && phase_two); k++)
      @(posedge clk_sys) #1;
    // pulses stand only now; the strobe counts land one edge later
    s_pw = push_write;
    s_dw = dec_write;
    s_id = int_done;
    s_ce = cycle_end;
    @(posedge clk_sys) #1;
  endtask
  // work out the expected outcome of one request, then run and compare
  task automatic run_row(input row_type r);
    logic [15:0] nx;
    logic [15:0] ps;
    logic        tk;
    logic        pw;
    logic        rt;
    logic [15:0] lp;
    acc = r.av;
    lp = e_pc;
    int_in_progress = r.ii;
    nx = e_pc + 16'h0002;
    ps = 16'h0000;
    tk = 1'b0;
    pw = (r.op == op_long_call || r.op == op_page_call);
    rt = (r.op == op_return || r.op == op_interrupt_return);
    case (r.op)
      op_long_jump, op_long_call: begin
        ps = e_pc + 16'h0003;
        nx = r.bb;
      end
      op_page_jump, op_page_call: begin
        ps = nx;
        nx = {nx[15:11], r.hi, r.bb[15:8]};
      end
      op_short_jump: tk = 1'b1;
      op_indexed_jump: nx = data_pointer + {8'h00, r.av};
      op_return, op_interrupt_return: nx = return_addr;
      op_branch_if_acc_zero: tk = (r.av == 8'h00);
      op_branch_if_acc_nonzero: tk = (r.av != 8'h00);
      op_decrement_branch_nonzero: begin
        nx = e_pc + 16'h0003;
        tk = (r.ab[15:8] != 8'h01);
      end
      op_compare_branch_unequal: begin
        nx = e_pc + 16'h0003;
        tk = (r.ab[15:8] != r.ab[7:0]);
        e_c = (r.ab[15:8] < r.ab[7:0]);
      end
      default: nx = e_pc + 16'h0001;
    endcase
    e_pc = tk ? nx + {{8{r.bb[15]}}, r.bb[15:8]} : nx;
    e_sp = e_sp + (pw ? 8'h02 : 8'h00) - (rt ? 8'h02 : 8'h00);
    issue('{r.op, r.hi, r.bb[15:8], r.bb[7:0], r.ab[15:8], r.ab[7:0]});
    chk_word("pc", e_pc, pc);
    chk_word("sp", {8'h00, e_sp}, {8'h00, sp});
    chk_bit("push_write", pw, s_pw);
    if (pw) chk_word("push_data", ps, push_data);
    chk_bit("carry", e_c, carry);
    chk_bit("dec_write", r.op == op_decrement_branch_nonzero,
            s_dw);
    if (r.op == op_decrement_branch_nonzero)
      chk_word("dec", {8'h00, r.ab[15:8] - 8'h01},
               {8'h00, dec_result});
    chk_bit("int_done", r.op == op_interrupt_return && r.ii,
            s_id);
    chk_bit("cycle_end", 1'b1, s_ce);
    chk_word("cycle", 16'd12, {11'h000, cyc_len});
    chk_word("latch", 16'h2, {12'h000, al_seen});
    chk_word("fetch", external_program ? 16'h2 : 16'h0,
             {12'h0, ps_seen});
    if (external_program)
      chk_word("latch_byte", {8'h00, lp[7:0] + 8'h01},
               {8'h00, latch_byte});
  endtask
  // watchdog: about 20 machine cycles of 600 ns are needed
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
  initial begin
    rows = '{
      '{op_long_jump,3'h0,16'h1234,8'h00,16'h0000,1'b0},
      '{op_short_jump,3'h0,16'h8000,8'h00,16'h0000,1'b0},
      '{op_short_jump,3'h0,16'h7F00,8'h00,16'h0000,1'b0},
      '{op_page_jump,3'h5,16'hA500,8'h00,16'h0000,1'b0},
      '{op_long_call,3'h0,16'h4321,8'h00,16'h0000,1'b0},
      '{op_return,3'h0,16'h0000,8'h00,16'h0000,1'b0},
      '{op_page_call,3'h7,16'hF000,8'h00,16'h0000,1'b0},
      '{op_interrupt_return,3'h0,16'h0,8'h00,16'h0,1'b1},
      '{op_interrupt_return,3'h0,16'h0,8'h00,16'h0,1'b0},
      '{op_indexed_jump,3'h0,16'h0000,8'h20,16'h0000,1'b0},
      '{op_branch_if_acc_zero,3'h0,16'h1000,8'h00,16'h0,1'b0},
      '{op_branch_if_acc_zero,3'h0,16'h1000,8'h01,16'h0,1'b0},
      '{op_branch_if_acc_nonzero,3'h0,16'hFE00,8'h01,16'h0,1'b0},
      '{op_decrement_branch_nonzero,3'h0,16'hF000,8'h00,16'h0100,1'b0},
      '{op_decrement_branch_nonzero,3'h0,16'hF000,8'h00,16'h0200,1'b0},
      '{op_compare_branch_unequal,3'h0,16'h0400,8'h00,16'h0305,1'b0},
      '{op_compare_branch_unequal,3'h0,16'h0400,8'h00,16'h0505,1'b0},
      '{op_compare_branch_unequal,3'h0,16'h8000,8'h00,16'h0905,1'b0}};
    e_pc = PC_RESET;
    e_sp = SP_RESET;
    e_c = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 srst = 1'b0;
    // alternate program memory location row by row
    foreach (rows[i]) begin
      external_program = i[0];
      run_row(rows[i]);
    end
    // data move: its second cycle refuses a request and drops fetches
    external_program = 1'b1;
    run_row('{op_external_data_move, 3'h0, 16'h0, 8'h00, 16'h0, 1'b0});
    issue('{op_short_jump, 3'h0, 8'h10, 8'h00, 8'h00, 8'h00});
    chk_word("pc", e_pc, pc);
    chk_word("latch", 16'h1, {12'h000, al_seen});
    chk_word("fetch", 16'h0, {12'h000, ps_seen});
    // reset in mid-run
    srst = 1'b1;
    req_valid = 1'b0;
    @(posedge clk_sys) #1;
    srst = 1'b0;
    chk_word("pc", PC_RESET, pc);
    chk_word("sp", {8'h00, SP_RESET}, {8'h00, sp});
    chk_bit("carry", 1'b0, carry);
    chk_bit("prog_store_n", 1'b1, bus.prog_store_n);
    chk_word("state", 16'h0, {13'h0000, state_num});
    // first edge after release: latch strobe of first_state, phase one
    @(posedge clk_sys) #1;
    chk_bit("addr_latch", 1'b1, bus.addr_latch);
    chk_bit("phase_two", 1'b0, phase_two);
    end_sim();
  end
endmodule
`default_nettype wire
